// *** logic/lbct_bus_controller.sv ***
/*
  Local bus command controller: sequences status and command states, drives the
  memory read and write strobes, the transceiver direction and enable.
  Assumes cycle requests, command delay and ready inputs synchronous to i_clock;
  the ready inputs come from external decode logic.
*/
`timescale 1ns/1ps
`default_nettype none

module lbct_bus_controller
  import lbct_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // cycle request from the processor side
  input wire logic i_cycle_start,
  input wire logic i_cycle_read,
  input wire logic i_command_delay_input,
  output logic o_cycle_ready,
  output logic o_cycle_done,
  output logic [WAIT_WIDTH-1:0] o_wait_count,
  // ready inputs, active low
  input wire logic i_async_ready_input_n,
  input wire logic i_sync_ready_input_n,
  // bus pins
  output logic o_memory_read_strobe_n,
  output logic o_memory_write_strobe_n,
  output logic o_transceiver_direction,
  output logic o_transceiver_enable
);
  // ---------------------------------------------------------------------
  // phase ticks
  // ---------------------------------------------------------------------
  logic fall_tick;

  lbct_clock_phase u_phase
  (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .o_fall_tick(fall_tick)
  );

  // ---------------------------------------------------------------------
  // bus state
  // ---------------------------------------------------------------------
  lbct_state_t state;
  lbct_state_t next_state;
  logic half;
  logic next_half;
  logic is_read;
  logic next_is_read;
  logic delayed;
  logic next_delayed;
  logic [WAIT_WIDTH-1:0] waits;
  logic [WAIT_WIDTH-1:0] next_waits;
  logic rd_n;
  logic next_rd_n;
  logic wr_n;
  logic next_wr_n;
  logic dir;
  logic next_dir;
  logic en;
  logic next_en;
  logic done;
  logic next_done;
  logic ready_hit;

  // either ready input ends the cycle; both are expected from decode logic
  assign ready_hit = !i_async_ready_input_n || !i_sync_ready_input_n; // R06
  assign o_cycle_ready = (state == LBCT_IDLE) && fall_tick;

  always_comb
  begin
    next_state = state;
    next_half = half;
    next_is_read = is_read;
    next_delayed = delayed;
    next_waits = waits;
    next_rd_n = rd_n;
    next_wr_n = wr_n;
    next_dir = dir;
    next_en = en;
    next_done = 1'b0;
    if (fall_tick)
    begin
      case (state)
        LBCT_IDLE:
        begin
          if (i_cycle_start)
          begin
            next_state = LBCT_STATUS; // R15
            next_half = 1'b0;
            next_is_read = i_cycle_read;
            next_delayed = i_command_delay_input; // R03
            next_waits = '0;
          end
        end
        LBCT_STATUS:
        begin
          if (!half)
          begin
            next_half = 1'b1;
            // receive is set up a full tick before the enable opens
            if (is_read)
              next_dir = DIRECTION_RECEIVE; // R12
            else
              next_en = 1'b1;
          end
          else
          begin
            next_state = LBCT_COMMAND; // R15
            next_half = 1'b0;
            if (!delayed)
            begin
              next_rd_n = !is_read; // R01 R11
              next_wr_n = is_read; // R01
            end
            if (is_read)
              next_en = 1'b1; // R12
          end
        end
        LBCT_COMMAND:
        begin
          if (!half)
          begin
            next_half = 1'b1;
            if (delayed)
            begin
              next_rd_n = !is_read; // R03
              next_wr_n = is_read; // R03
            end
          end
          else if (ready_hit)
          begin
            // cycle length depends on ready only, never on the delay
            next_state = LBCT_IDLE; // R04
            next_rd_n = STROBE_IDLE_N; // R02
            next_wr_n = STROBE_IDLE_N; // R02
            next_dir = DIRECTION_TRANSMIT; // R14
            next_en = ENABLE_OFF;
            next_done = 1'b1;
          end
          else
          begin
            // wait state repeats the command state: two more ticks, four clocks
            next_half = 1'b0; // R05 R10
            if (waits != '1)
              next_waits = waits + 1'b1;
          end
        end
        default:
        begin
          next_state = LBCT_IDLE;
          next_rd_n = STROBE_IDLE_N;
          next_wr_n = STROBE_IDLE_N;
          next_dir = DIRECTION_TRANSMIT;
          next_en = ENABLE_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state <= LBCT_IDLE;
      half <= 1'b0;
      is_read <= 1'b0;
      delayed <= 1'b0;
      waits <= '0;
      rd_n <= STROBE_IDLE_N;
      wr_n <= STROBE_IDLE_N;
      dir <= DIRECTION_TRANSMIT;
      en <= ENABLE_OFF;
      done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      half <= next_half;
      is_read <= next_is_read;
      delayed <= next_delayed;
      waits <= next_waits;
      rd_n <= next_rd_n;
      wr_n <= next_wr_n;
      dir <= next_dir;
      en <= next_en;
      done <= next_done;
    end
  end

  assign o_memory_read_strobe_n = rd_n;
  assign o_memory_write_strobe_n = wr_n;
  assign o_transceiver_direction = dir;
  assign o_transceiver_enable = en;
  assign o_cycle_done = done;
  assign o_wait_count = waits;

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  logic [TICK_COUNT_WIDTH-1:0] cyc_ticks;
  logic [TICK_COUNT_WIDTH-1:0] strobe_ticks;
  logic strobe_on;

  assign strobe_on = !rd_n || !wr_n;

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cyc_ticks <= '0;
      strobe_ticks <= '0;
    end
    else if (fall_tick)
    begin
      cyc_ticks <= (state == LBCT_IDLE) ? '0 : cyc_ticks + 1'b1;
      strobe_ticks <= (state == LBCT_IDLE) ? '0 : strobe_ticks + TICK_COUNT_WIDTH'(strobe_on);
    end
  end

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  AST_STROBE_AT_COMMAND_ENTRY: assert property ( // R01
    fall_tick && state == LBCT_STATUS && half && !delayed |=> strobe_on)
    else $error("strobe not active at command state entry");

  AST_STROBE_OFF_AT_END: assert property ( // R02
    o_cycle_done |-> rd_n && wr_n && $past(strobe_on))
    else $error("strobe not released at end of command state");

  AST_DELAY_POSTPONES: assert property ( // R03
    fall_tick && state == LBCT_STATUS && half && delayed |=> !strobe_on && state == LBCT_COMMAND)
    else $error("delayed command went active too early");

  AST_CYCLE_LENGTH: assert property ( // R04
    o_cycle_done |-> cyc_ticks == TICK_COUNT_WIDTH'(4) + TICK_COUNT_WIDTH'({waits, 1'b0}))
    else $error("cycle length not set by wait states alone");

  AST_STROBE_WIDTH: assert property ( // R05
    o_cycle_done |-> strobe_ticks ==
      TICK_COUNT_WIDTH'(2) + TICK_COUNT_WIDTH'({waits, 1'b0}) - TICK_COUNT_WIDTH'(delayed))
    else $error("strobe width wrong for wait count");

  AST_WAIT_REPEATS_COMMAND: assert property ( // R10
    fall_tick && state == LBCT_COMMAND && half && !ready_hit |=> state == LBCT_COMMAND && !half)
    else $error("no repeated command state after missing ready");

  AST_READ_STROBE_ONLY_READ: assert property ( // R11
    !rd_n |-> is_read && wr_n)
    else $error("read strobe outside a read cycle");

  AST_DIR_BEFORE_ENABLE: assert property ( // R12
    $rose(en) && is_read |-> !dir && !$past(dir))
    else $error("transceiver enabled before receive direction");

  AST_DIR_WRITE_STEADY: assert property ( // R14
    state != LBCT_IDLE && !is_read |-> dir)
    else $error("direction changed in a write cycle");

  AST_IDLE_PINS: assert property ( // R14
    state == LBCT_IDLE |-> dir && !en && rd_n && wr_n)
    else $error("bus pins not at rest while idle");

  COVER_READ_NO_WAIT: cover property (o_cycle_done && is_read && waits == '0);
  COVER_WRITE_DELAYED: cover property (o_cycle_done && !is_read && delayed);
  COVER_READ_WAITS: cover property (o_cycle_done && is_read && waits == WAIT_WIDTH'(2));
endmodule : lbct_bus_controller

`default_nettype wire

// *** logic/lbct_clock_phase.sv ***
/*
  Constants package for the local bus command timing block, and the divider that
  turns the fast clock into one-cycle ticks marking each falling processor clock edge.
  Assumes a single free-running clock and an asynchronous active-low reset.
*/
// Function
// R01: assert strobe on fall entering command state
// R02: drop strobe on fall ending command state
// R03: command delay input postpones strobe activation
// R04: command delay never lengthens bus cycle
// R05: each wait adds two clocks strobe
// R06: ready derives from address decode, commands
// R07: zero wait: async ready not command gated
// R08: zero wait: sync ready may use command
// R09: with waits either ready may use command
// R10: each wait gives ready logic two clocks
// R11: read strobe active early in command state
// R12: read: direction low, then transceiver enable
// R13: device data valid before command end
// R14: direction returns transmit, steady during writes
// R15: status state, then repeating command states
`timescale 1ns/1ps
`default_nettype none

package lbct_pkg;
  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 4;
  localparam int PROC_CLOCK_PERIOD_NS = 8;
  localparam int PHASE_DIV = (PROC_CLOCK_PERIOD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int TICKS_PER_STATE = 2;
  localparam int WAIT_WIDTH = 4;
  localparam int TICK_COUNT_WIDTH = 8;
  // -------------------------------------------------------------------
  // reset values of the pins, and the receive direction
  // -------------------------------------------------------------------
  localparam logic STROBE_IDLE_N = 1'b1;
  localparam logic DIRECTION_TRANSMIT = 1'b1;
  localparam logic DIRECTION_RECEIVE = 1'b0;
  localparam logic ENABLE_OFF = 1'b0;
  // -------------------------------------------------------------------
  // bus states
  // -------------------------------------------------------------------
  typedef enum logic [1:0]
  {
    LBCT_IDLE = 2'b00,
    LBCT_STATUS = 2'b01,
    LBCT_COMMAND = 2'b10
  } lbct_state_t;
endpackage : lbct_pkg

module lbct_clock_phase
  import lbct_pkg::*;
#(
  parameter int DIVIDE = PHASE_DIV
)
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // falling processor clock edge
  output logic o_fall_tick
);
  logic [7:0] count;
  logic [7:0] next_count;

  always_comb
  begin
    if (count == 8'(DIVIDE - 1))
      next_count = 8'h00;
    else
      next_count = count + 8'h01;
  end

  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      count <= 8'h00;
    else
      count <= next_count;
  end

  assign o_fall_tick = (count == 8'(DIVIDE - 1));
endmodule : lbct_clock_phase

`default_nettype wire

// *** testbench/lbct_ready_model.sv ***
/*
  Far-side model: address decode and ready generation of a memory device.
  Assumes the bench raises i_select when a cycle is taken and drops it after done.
*/
`timescale 1ns/1ps
`default_nettype none

module lbct_ready_model
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // decode and settings from the bench
  input wire logic i_select,
  input wire logic i_use_sync,
  input wire logic [3:0] i_waits,
  // command strobes from the controller
  input wire logic i_read_strobe_n,
  input wire logic i_write_strobe_n,
  // ready outputs, idle high as if pulled up
  output logic o_async_ready_n,
  output logic o_sync_ready_n
);
  logic [7:0] count;
  logic due;
  always_ff @(posedge i_clock or negedge i_rst_n)
  begin
    if (!i_rst_n)
      count <= 8'h00;
    else if (!i_select)
      count <= 8'h00;
    else if (count != 8'hff)
      count <= count + 8'h01;
  end
  // each wait state is two ticks, four clocks; ready lands four clocks before the wanted tick
  assign due = i_select && (count >= {2'b00, i_waits, 2'b00} + 8'h04);
  // async ready from decode alone, never gated by a strobe
  assign o_async_ready_n = !(due && !i_use_sync);
  // sync ready qualified by an active strobe
  assign o_sync_ready_n = !(due && i_use_sync && !(i_read_strobe_n && i_write_strobe_n));
endmodule : lbct_ready_model

`default_nettype wire

// *** testbench/local_bus_command_ready_timing_tb.sv ***
/*
  Self-checking bench for the bus controller with the ready model on the far side.
  Assumes a 4 ns clock and one processor clock tick every two clocks.
*/
`timescale 1ns/1ps
`default_nettype none

module local_bus_command_ready_timing_tb;
  logic i_clock = 1'b0;
  logic i_rst_n = 1'b0;
  logic start = 1'b0;
  logic rd = 1'b0;
  logic dly = 1'b0;
  logic sel = 1'b0;
  logic sync = 1'b0;
  logic [3:0] waits = 4'h0;
  logic ready, done, async_ready_input_n, sync_ready_input_n, rd_n, wr_n, dir, en;
  logic [3:0] wcount;
  int err_count = 0;
  int tests_run = 0;

  always #2 i_clock = ~i_clock;

  lbct_bus_controller lbct_bus_controller_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_cycle_start(start), .i_cycle_read(rd), .i_command_delay_input(dly),
    .o_cycle_ready(ready), .o_cycle_done(done), .o_wait_count(wcount),
    .i_async_ready_input_n(async_ready_input_n), .i_sync_ready_input_n(sync_ready_input_n),
    .o_memory_read_strobe_n(rd_n), .o_memory_write_strobe_n(wr_n),
    .o_transceiver_direction(dir), .o_transceiver_enable(en));

  lbct_ready_model lbct_ready_model_inst (.i_clock(i_clock), .i_rst_n(i_rst_n),
    .i_select(sel), .i_use_sync(sync), .i_waits(waits), .i_read_strobe_n(rd_n),
    .i_write_strobe_n(wr_n), .o_async_ready_n(async_ready_input_n), .o_sync_ready_n(sync_ready_input_n));

  // -------------------------------------------------------------------
  // shared tasks
  // -------------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic close_out();
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  // called at a rising edge; holds the request until a tick takes it
  task automatic take(input logic r, input logic d, input logic s, input logic [3:0] w);
    int k;
    rd <= r;
    dly <= d;
    sync <= s;
    waits <= w;
    start <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(negedge i_clock);
      if (ready === 1'b1)
        break;
    end
    if (k == 20)
    begin
      err_count++;
      close_out();
    end
    @(posedge i_clock);
    start <= 1'b0;
    sel <= 1'b1;
  endtask : take

  task automatic run_cycle(input logic r, input logic d, input logic s, input logic [3:0] w);
    int k, first, width, done_k;
    logic bad;
    take(r, d, s, w);
    first = 0;
    width = 0;
    done_k = 0;
    bad = 1'b0;
    for (k = 1; k <= 90 && done_k == 0; k++)
    begin
      @(negedge i_clock);
      if ((r ? rd_n : wr_n) === 1'b0)
      begin
        width++;
        if (first == 0)
          first = k;
      end
      if ((r ? wr_n : rd_n) !== 1'b1)
        bad = 1'b1;
      if ((en === 1'b1 && dir !== !r) || (!r && dir !== 1'b1))
        bad = 1'b1;
      if (done === 1'b1)
        done_k = k;
    end
    if (done_k == 0)
    begin
      err_count++;
      close_out();
    end
    check("strobe start", 8'(first), 8'(5 + 2 * d));
    check("strobe width", 8'(width), 8'((2 + 2 * w - d) * 2));
    check("cycle length", 8'(done_k - 1), 8'((4 + 2 * w) * 2));
    check("wait count", {4'h0, wcount}, {4'h0, w});
    check("transceiver use", {7'h00, bad}, 8'h00);
    check("idle pins", {4'h0, dir, en, rd_n, wr_n}, 8'h0b);
    @(posedge i_clock);
    sel <= 1'b0;
  endtask : run_cycle

  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task automatic scn_read_zero_wait();
    run_cycle(1'b1, 1'b0, 1'b0, 4'h0);
  endtask : scn_read_zero_wait

  task automatic scn_write_delay_sync();
    run_cycle(1'b0, 1'b1, 1'b1, 4'h0);
  endtask : scn_write_delay_sync

  task automatic scn_waits_back_to_back();
    run_cycle(1'b1, 1'b1, 1'b1, 4'h2);
    run_cycle(1'b0, 1'b0, 1'b0, 4'h3);
    run_cycle(1'b1, 1'b0, 1'b1, 4'h1);
  endtask : scn_waits_back_to_back

  // reset in the middle of a read with waits, then a clean write
  task automatic scn_reset_mid();
    take(1'b1, 1'b0, 1'b0, 4'h4);
    repeat (8) @(posedge i_clock);
    i_rst_n <= 1'b0;
    sel <= 1'b0;
    @(negedge i_clock);
    check("reset pins", {2'h0, done, dir, en, rd_n, wr_n, 1'b0}, 8'h16);
    check("reset wait count", {4'h0, wcount}, 8'h00);
    @(posedge i_clock);
    i_rst_n <= 1'b1;
    run_cycle(1'b0, 1'b0, 1'b0, 4'h0);
  endtask : scn_reset_mid

  initial
  begin
    repeat (6) @(posedge i_clock);
    i_rst_n <= 1'b1;
    scn_read_zero_wait();
    scn_write_delay_sync();
    scn_waits_back_to_back();
    scn_reset_mid();
    close_out();
  end
endmodule : local_bus_command_ready_timing_tb

`default_nettype wire
